// ### pods_defs.vh
// Behaviour
// - wait turn-on interval before raising output
// - on interval: 8-bit ms, reset zero
// - on interval register at 0x05, RW
// - slewed off interval ends at zero volts
// - unslewed off interval ends with switches open
// - slewed hold time equals interval minus ramp time
// - unslewed off: just open both switches
// - droop select picks one of eight values
// - droop lowers target with output current
// - off interval six bits, reset 11 ms
// - ramps move target in 10 mV steps
`ifndef PODS_DEFS_VH
`define PODS_DEFS_VH
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PODS_ADDR_ON      8'h05
`define PODS_ADDR_OFF     8'h06
`define PODS_ON_RST       8'h00
`define PODS_OFF_RST      6'h0B
`define PODS_OFF_W        6
// ----------------------------------------------------------------
// timing and scaling
// ----------------------------------------------------------------
// master-clock periods per millisecond (1 MHz master clock)
`define PODS_MCLK_PER_MS  1000
// 10 mV in setpoint units of 2.5 mV
`define PODS_STEP_LSB     12'h004
// droop: 0.37 mV/A per select step, iout in 1/16 A, scaled by 2^12
`define PODS_DROOP_K      12'h026
`define PODS_DROOP_SHIFT  12
`endif

// ### pods_ms_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "pods_defs.vh"
module pods_ms_tick #(
	parameter MCLK_PER_MS = `PODS_MCLK_PER_MS
) (
	// clock and reset
	input  wire        ref_clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// shared master clock pin
	input  wire        mclk_i,
	// ticks
	output reg         mclk_tick_o,
	output reg         ms_tick_o
);
	reg        mclk_s1;
	reg        mclk_s2;
	reg        mclk_d;
	reg [15:0] div_cnt;

	// ----------------------------------------------------------------
	// pin sync, rising-edge detect, millisecond divider
	// ----------------------------------------------------------------
	// dividing the shared clock keeps every converter's delays aligned
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			mclk_s1     <= 1'b0;
			mclk_s2     <= 1'b0;
			mclk_d      <= 1'b0;
			div_cnt     <= 16'h0000;
			mclk_tick_o <= 1'b0;
			ms_tick_o   <= 1'b0;
		end
		else if (ce_i)
		begin
			mclk_s1     <= mclk_i;
			mclk_s2     <= mclk_s1;
			mclk_d      <= mclk_s2;
			mclk_tick_o <= mclk_s2 & ~mclk_d;
			ms_tick_o   <= 1'b0;
			if (mclk_s2 & ~mclk_d)
			begin
				if (div_cnt == MCLK_PER_MS[15:0] - 16'h0001)
				begin
					div_cnt   <= 16'h0000;
					ms_tick_o <= 1'b1;
				end
				else
					div_cnt <= div_cnt + 16'h0001;
			end
		end
	end
endmodule // pods_ms_tick
`default_nettype wire

// ### pods_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "pods_defs.vh"
module pods_sequencer #(
	parameter MCLK_PER_MS = `PODS_MCLK_PER_MS
) (
	// clock, reset, enable
	input  wire        ref_clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// shared master clock pin
	input  wire        mclk_i,
	// configuration register port
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	output reg  [7:0]  reg_rdata_o,
	// run control and settings from the rest of the controller
	input  wire        run_i,
	input  wire [11:0] vset_i,
	input  wire        rise_slew_en_i,
	input  wire [7:0]  rise_step_i,
	input  wire        fall_slew_en_i,
	input  wire [7:0]  fall_step_i,
	input  wire [2:0]  droop_sel_i,
	input  wire [11:0] iout_i,
	// outputs to the power stage
	output reg  [11:0] vref_o,
	output reg         sw_en_o,
	output reg  [2:0]  state_o
);
	localparam [2:0] ST_OFF    = 3'd0;
	localparam [2:0] ST_ONWAIT = 3'd1;
	localparam [2:0] ST_RISE   = 3'd2;
	localparam [2:0] ST_ON     = 3'd3;
	localparam [2:0] ST_HOLD   = 3'd4;
	localparam [2:0] ST_FALL   = 3'd5;

	reg [7:0]               on_interval_reg;
	reg [`PODS_OFF_W-1:0]   off_interval_reg;
	reg [2:0]               state;
	reg [11:0]              vramp;
	reg [23:0]              hold_cnt;
	reg [7:0]               step_cnt;
	reg                     run_d;
	wire                    mclk_tick;
	wire                    ms_tick;
	wire [23:0]             off_mclk;
	wire [23:0]             ramp_mclk;
	wire [11:0]             vout_now;
	wire [11:0]             droop;

	pods_ms_tick #(
		.MCLK_PER_MS (MCLK_PER_MS)
	) u_tick (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.mclk_i      (mclk_i),
		.mclk_tick_o (mclk_tick),
		.ms_tick_o   (ms_tick)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// droop offset in setpoint units: iout * sel * k >> shift
	function [11:0] droop_lsb;
		input [11:0] iout;
		input [2:0]  sel;
		reg   [26:0] prod;
		begin
			prod      = {15'h0000, iout} * {24'h000000, sel}
				* {15'h0000, `PODS_DROOP_K};
			droop_lsb = prod[`PODS_DROOP_SHIFT+11:`PODS_DROOP_SHIFT];
		end
	endfunction

	// one 10 mV step toward a target, clamped so it never overshoots
	function [11:0] step_toward;
		input [11:0] cur;
		input [11:0] tgt;
		begin
			if (tgt > cur)
				step_toward = (tgt - cur > `PODS_STEP_LSB) ?
					cur + `PODS_STEP_LSB : tgt;
			else
				step_toward = (cur - tgt > `PODS_STEP_LSB) ?
					cur - `PODS_STEP_LSB : tgt;
		end
	endfunction

	assign vout_now  = vramp;
	// ramp-down time in master-clock periods: steps times step length
	assign ramp_mclk = ({12'h000, (vout_now + `PODS_STEP_LSB - 12'h001)
		>> 2}) * {16'h0000, fall_step_i};
	assign off_mclk  = {18'h00000, off_interval_reg}
		* {6'h00, MCLK_PER_MS[17:0]};
	assign droop     = droop_lsb(iout_i, droop_sel_i);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			on_interval_reg  <= `PODS_ON_RST;
			off_interval_reg <= `PODS_OFF_RST;
			reg_rdata_o      <= 8'h00;
		end
		else if (ce_i)
		begin
			if (reg_wr_i && reg_addr_i == `PODS_ADDR_ON)
				on_interval_reg <= reg_wdata_i;
			else if (reg_wr_i && reg_addr_i == `PODS_ADDR_OFF)
				off_interval_reg <= reg_wdata_i[`PODS_OFF_W-1:0];
			if (reg_rd_i)
			begin
				if (reg_addr_i == `PODS_ADDR_ON)
					reg_rdata_o <= on_interval_reg;
				else if (reg_addr_i == `PODS_ADDR_OFF)
					reg_rdata_o <= {2'b00, off_interval_reg};
				else
					reg_rdata_o <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencing state machine
	// ----------------------------------------------------------------
	always @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			state    <= ST_OFF;
			vramp    <= 12'h000;
			hold_cnt <= 24'h000000;
			step_cnt <= 8'h00;
			run_d    <= 1'b0;
			sw_en_o  <= 1'b0;
			vref_o   <= 12'h000;
			state_o  <= ST_OFF;
		end
		else if (ce_i)
		begin
			run_d   <= run_i;
			state_o <= state;
			// droop lowers the target as current rises
			vref_o  <= (droop > vramp) ? 12'h000 : vramp - droop;
			case (state)
			ST_OFF:
			begin
				sw_en_o <= 1'b0;
				vramp   <= 12'h000;
				if (run_i && !run_d)
				begin
					hold_cnt <= {16'h0000, on_interval_reg};
					state    <= ST_ONWAIT;
				end
			end
			ST_ONWAIT:
			begin
				if (!run_i)
					state <= ST_OFF;
				else if (hold_cnt == 24'h000000)
				begin
					sw_en_o  <= 1'b1;
					step_cnt <= 8'h00;
					state    <= ST_RISE;
				end
				else if (ms_tick)
					hold_cnt <= hold_cnt - 24'h000001;
			end
			ST_RISE:
			begin
				if (!rise_slew_en_i)
				begin
					vramp <= vset_i;
					state <= ST_ON;
				end
				else if (vramp == vset_i)
					state <= ST_ON;
				else if (mclk_tick)
				begin
					if (step_cnt >= rise_step_i)
					begin
						step_cnt <= 8'h00;
						vramp    <= step_toward(vramp, vset_i);
					end
					else
						step_cnt <= step_cnt + 8'h01;
				end
			end
			ST_ON:
			begin
				// setpoint changes while on follow at once
				vramp <= vset_i;
				if (!run_i && run_d)
				begin
					state <= ST_HOLD;
					if (fall_slew_en_i)
						// hold = interval - ramp time, floored at zero
						hold_cnt <= (off_mclk > ramp_mclk) ?
							off_mclk - ramp_mclk : 24'h000000;
					else
						hold_cnt <= {18'h00000, off_interval_reg};
				end
			end
			ST_HOLD:
			begin
				if (hold_cnt == 24'h000000)
				begin
					step_cnt <= 8'h00;
					if (fall_slew_en_i)
						state <= ST_FALL;
					else
					begin
						// no shaping: decay is left to the load
						sw_en_o <= 1'b0;
						vramp   <= 12'h000;
						state   <= ST_OFF;
					end
				end
				else if (fall_slew_en_i ? mclk_tick : ms_tick)
					hold_cnt <= hold_cnt - 24'h000001;
			end
			ST_FALL:
			begin
				if (vramp == 12'h000)
				begin
					sw_en_o <= 1'b0;
					state   <= ST_OFF;
				end
				else if (mclk_tick)
				begin
					if (step_cnt >= fall_step_i - 8'h01)
					begin
						step_cnt <= 8'h00;
						vramp    <= step_toward(vramp, 12'h000);
					end
					else
						step_cnt <= step_cnt + 8'h01;
				end
			end
			default:
				state <= ST_OFF;
			endcase
		end
	end
endmodule // pods_sequencer
`default_nettype wire

// ### pods_mgr.sv
`timescale 1ns/1ps
`default_nettype none
module pods_mgr (
	// clock, master clock and register port
	input  wire logic       clk_i,
	output logic            mclk_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic [7:0]      addr_o,
	output logic [7:0]      wdata_o
);
	// free-running shared clock, 8 system cycles per period
	initial mclk_o = 0;
	always #20 mclk_o = !mclk_o;
	initial
	begin
		wr_o = 0;
		rd_o = 0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end
	// one byte per access; lines scrambled once released
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge clk_i);
		wr_o = w;
		rd_o = !w;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		wr_o = 0;
		rd_o = 0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask
endmodule // pods_mgr
`default_nettype wire

// ### pods_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pods_seq_sva (
	// watched ports
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        reg_rd_i,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [7:0]  reg_rdata_o,
	input wire logic        run_i,
	input wire logic [11:0] vset_i,
	input wire logic [2:0]  droop_sel_i,
	input wire logic [11:0] vref_o,
	input wire logic        sw_en_o,
	input wire logic [2:0]  state_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// a read is only taken while the clock enable is high
	property p_off_rd;
		ce_i && reg_rd_i && reg_addr_i == 8'h06
			|=> reg_rdata_o[7:6] == 2'h0;
	endproperty
	a_off_rd: assert property (p_off_rd)
		else $error("off reg top bits set");
	property p_unmap;
		ce_i && reg_rd_i && reg_addr_i == 8'h07
			|=> reg_rdata_o == 8'h00;
	endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_rd_hold;
		!(ce_i && reg_rd_i) |=> $stable(reg_rdata_o);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved without read");
	property p_on_hold;
		$rose(run_i) && state_o == 3'h0 |=> !sw_en_o;
	endproperty
	a_on_hold: assert property (p_on_hold)
		else $error("switches on at turn-on edge");
	property p_on_sw;
		state_o == 3'h3 |-> sw_en_o;
	endproperty
	a_on_sw: assert property (p_on_sw)
		else $error("on state without switches");
	// unslewed, the target clears one cycle after the switches open
	property p_off_end;
		$fell(sw_en_o) |-> !run_i ##1 vref_o == 12'h000;
	endproperty
	a_off_end: assert property (p_off_end)
		else $error("switches opened badly");
	property p_rise;
		state_o == 3'h2 && $past(state_o) == 3'h2 && $changed(vref_o)
			|-> vref_o - $past(vref_o) == 12'h004;
	endproperty
	a_rise: assert property (p_rise)
		else $error("rise step not 10 mV");
	property p_droop0;
		state_o == 3'h3 && $past(state_o) == 3'h3 && droop_sel_i == 3'h0
			&& $past(droop_sel_i) == 3'h0 && $stable(vset_i)
			|-> vref_o == vset_i;
	endproperty
	a_droop0: assert property (p_droop0)
		else $error("zero droop moved target");
endmodule // pods_seq_sva
bind pods_sequencer pods_seq_sva chk (.ref_clk_i(ref_clk_i),
	.rst_i(rst_i), .ce_i(ce_i), .reg_rd_i(reg_rd_i),
	.reg_addr_i(reg_addr_i),
	.reg_rdata_o(reg_rdata_o), .run_i(run_i), .vset_i(vset_i),
	.droop_sel_i(droop_sel_i), .vref_o(vref_o), .sw_en_o(sw_en_o),
	.state_o(state_o));
`default_nettype wire

// ### pods_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pods_sequencer_tb;
	logic        clk = 0, rst = 1, run = 0, fse = 1, sw, mclk, wr, rd;
	logic        ce = 1, rse = 1;
	logic [2:0]  droop = 3'h0, st;
	logic [7:0]  addr, wd, rdata;
	logic [11:0] iout = 12'h000, vref;
	int          fails = 0, cmp_count = 0, cyc = 0, n;
	always #2.5 clk = !clk;
	pods_mgr mgr (.clk_i(clk), .mclk_o(mclk), .wr_o(wr), .rd_o(rd),
		.addr_o(addr), .wdata_o(wd));
	pods_sequencer #(.MCLK_PER_MS(4)) dut (.ref_clk_i(clk), .rst_i(rst),
		.ce_i(ce), .mclk_i(mclk), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
		.run_i(run), .vset_i(12'h010), .rise_slew_en_i(rse),
		.rise_step_i(8'h01), .fall_slew_en_i(fse), .fall_step_i(8'h02),
		.droop_sel_i(droop), .iout_i(iout), .vref_o(vref), .sw_en_o(sw),
		.state_o(st));
	task automatic chk(input string nm, input logic [11:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic w_sw(input logic v);
		n = 0;
		while (sw !== v && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic w_st(input logic [2:0] s);
		for (int i = 0; i < 3000 && st !== s; i++)
			@(negedge clk);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk)
		if (++cyc > 6000)
		begin
			fails++;
			close_out;
		end
	task automatic t_regs;
		mgr.acc(0, 8'h05, 8'h00);
		chk("on rst", rdata, 8'h00);
		mgr.acc(0, 8'h06, 8'h00);
		chk("off rst", rdata, 8'h0B);
		mgr.acc(1, 8'h05, 8'hA5);
		mgr.acc(1, 8'h06, 8'hFF);
		mgr.acc(0, 8'h05, 8'h00);
		chk("on rw", rdata, 8'hA5);
		mgr.acc(0, 8'h06, 8'h00);
		chk("off rw", rdata, 8'h3F);
		mgr.acc(0, 8'h07, 8'h00);
		chk("unmapped", rdata, 8'h00);
		$display("t_regs done");
	endtask
	// 2 ms on, 3 ms off; 4 steps of 2 edges keep the hold above zero
	task automatic t_on_off(input logic slew);
		mgr.acc(1, 8'h05, 8'h02);
		mgr.acc(1, 8'h06, 8'h03);
		fse = slew;
		run = 1;
		w_sw(1);
		chk("on delay", n >= 28 && n <= 72, 1);
		w_st(3'h3);
		chk("ramp end", vref, 12'h010);
		// 2.6 mV/A at 4 A is 4.16 steps of 2.5 mV, truncated to 4
		droop = 3'h7;
		iout = 12'h040;
		repeat (4) @(negedge clk);
		chk("droop", vref, 12'h00C);
		droop = 3'h0;
		iout = 12'h000;
		repeat (4) @(negedge clk);
		run = 0;
		w_sw(0);
		chk("off delay", n >= 60 && n <= 112, 1);
		@(negedge clk);
		chk("off vref", vref, 12'h000);
		w_st(3'h0);
		$display("t_on_off done");
	endtask
	task automatic t_abort;
		mgr.acc(1, 8'h05, 8'h05);
		run = 1;
		repeat (10) @(negedge clk);
		run = 0;
		repeat (4) @(negedge clk);
		chk("abort st", st, 3'h0);
		chk("abort sw", sw, 1'b0);
		$display("t_abort done");
	endtask
	// writes are dropped and the turn-on edge waits while the enable is low
	task automatic t_freeze;
		mgr.acc(1, 8'h05, 8'h00);
		ce = 0;
		mgr.acc(1, 8'h05, 8'h33);
		run = 1;
		repeat (100) @(negedge clk);
		chk("frz sw", sw, 1'b0);
		chk("frz st", st, 3'h0);
		rse = 0;
		ce = 1;
		mgr.acc(0, 8'h05, 8'h00);
		chk("frz reg", rdata, 8'h00);
		chk("zero delay", sw, 1'b1);
		w_st(3'h3);
		chk("step rise", vref, 12'h010);
		run = 0;
		w_sw(0);
		chk("frz off", n >= 60 && n <= 112, 1);
		w_st(3'h0);
		rse = 1;
		$display("t_freeze done");
	endtask
	initial
	begin
		repeat (4) @(negedge clk);
		rst = 0;
		t_regs;
		t_on_off(1);
		t_on_off(0);
		t_abort;
		t_freeze;
		close_out;
	end
endmodule // pods_sequencer_tb
`default_nettype wire
